/* File: common/aplm_pkg.sv */
// Constants, register map and move sequencer states for the axis position and limit monitor
// Operation
// - Default-scaled positioning range spans -286435456 to 286435455 user units.
// - Only absolute profile-position moves must stay in range; others may overshoot.
// - Actual position beyond a range bound clears the reference-valid flag.
// - Relative profile-position move: predict absolute target against range before starting.
// - Predicted overshoot: set current position to 0, clear reference-valid, then move.
// - Software limit positions are relative to the axis zero point.
// - Software limits compare the position controller setpoint, not actual position.
// - A software limit trip sets bit 2 of the latched signal status.
// - Enable field: 0 none, 1 positive, 2 negative, 3 both directions.
// - Written software limit positions clamp to the user range, 2147483647 at most.
// - Both hardware limit inputs are monitored while a movement runs.
// - Reaching an active hardware limit stops the motor and reports the trip.
// - Each hardware limit input can be disabled, active low or active high.
// - Current motor position in user units is readable as a parameter.
package aplm_pkg;

	// Positioning range, default scaling: -286435456 and 286435455 usr
	localparam logic signed [31:0] RANGE_LO = 32'sheeed5780;
	localparam logic signed [31:0] RANGE_HI = 32'sh1112a87f;

	// User range extremes used for clamping written limits
	localparam logic signed [31:0] USR_MIN = 32'sh80000000;
	localparam logic signed [31:0] USR_MAX = 32'sh7fffffff;

	// Parameter addresses
	localparam logic [15:0] ADDR_SL_ENABLE = 16'h0606;
	localparam logic [15:0] ADDR_SL_POS = 16'h0608;
	localparam logic [15:0] ADDR_SL_NEG = 16'h060a;
	localparam logic [15:0] ADDR_SIG_LATCHED = 16'h0610;
	localparam logic [15:0] ADDR_EVAL_POS = 16'h0612;
	localparam logic [15:0] ADDR_EVAL_NEG = 16'h0614;
	localparam logic [15:0] ADDR_ACT_POS = 16'h0616;
	localparam logic [15:0] ADDR_REF_STATUS = 16'h0618;

	// Reset values
	localparam logic [1:0] RST_SL_ENABLE = 2'h0;
	localparam logic signed [31:0] RST_SL_POS = 32'sh7fffffff;
	localparam logic signed [31:0] RST_SL_NEG = 32'sh80000000;
	localparam logic [1:0] RST_EVAL = 2'h0;

	// Software limit enable field bits
	localparam int SLE_POS_BIT = 0;
	localparam int SLE_NEG_BIT = 1;

	// Hardware limit input evaluation codes
	localparam logic [1:0] EVAL_NONE = 2'h0;
	localparam logic [1:0] EVAL_ACT0 = 2'h1;
	localparam logic [1:0] EVAL_ACT1 = 2'h2;

	// Latched signal status bits
	localparam int LAT_HW_BIT = 1;
	localparam int LAT_SW_BIT = 2;

	// Move start sequencer
	typedef enum logic [2:0] {
		MV_IDLE = 3'h1,
		MV_CHECK = 3'h2,
		MV_ISSUE = 3'h4
	} aplm_move_state_type;

endpackage

/* File: design/aplm_range_cmp.sv */
// Signed window comparator on sign-extended positions
`timescale 1ns/1ps
module aplm_range_cmp
(
	// Value under test and window bounds
	input wire logic signed [32:0] value,
	input wire logic signed [32:0] lo,
	input wire logic signed [32:0] hi,
	// Results
	output logic below,
	output logic above
);

	// One bit wider than the operands so sums cannot wrap into the window
	assign below = value < lo;
	assign above = value > hi;

endmodule

/* File: design/aplm_monitor.sv */
// Axis position range, software limit and hardware limit monitor
`timescale 1ns/1ps
module aplm_monitor
(
	// Clock and reset
	input wire logic CLK,
	input wire logic RST,
	// Parameter access
	input wire logic [15:0] PAR_ADDR,
	input wire logic [31:0] PAR_WDATA,
	input wire logic PAR_WR,
	input wire logic PAR_RD,
	output logic [31:0] PAR_RDATA,
	output logic PAR_ACK,
	output logic PAR_ERR,
	// Position feedback and setpoint, raw axis frame
	input wire logic signed [31:0] ACT_RAW,
	input wire logic signed [31:0] SETP_RAW,
	input wire logic MOVING,
	// Move requests
	input wire logic MOVE_START,
	input wire logic MOVE_PP,
	input wire logic MOVE_REL,
	input wire logic signed [31:0] MOVE_VALUE,
	output logic MOVE_GO,
	output logic MOVE_REJECT,
	output logic signed [31:0] MOVE_TARGET,
	// Homing
	input wire logic HOME_DONE,
	input wire logic signed [31:0] HOME_POS,
	// Hardware limit contacts
	input wire logic HW_LIMIT_POSITIVE_IN,
	input wire logic HW_LIMIT_NEGATIVE_IN,
	// Status
	output logic REF_OK,
	output logic STOP_MOTOR,
	output logic POS_LIMIT_HIT,
	output logic NEG_LIMIT_HIT,
	output logic SW_LIMIT_HIT,
	output logic signed [31:0] ACT_POS
);

	aplm_pkg::aplm_move_state_type state_q;
	logic [1:0] soft_limit_enable_q;
	logic signed [31:0] soft_limit_positive_pos_q;
	logic signed [31:0] soft_limit_negative_pos_q;
	logic [1:0] pos_limit_input_eval_q;
	logic [1:0] neg_limit_input_eval_q;
	logic [2:0] latched_signal_status_q;
	logic [2:0] latched_signal_status_d;
	logic ref_ok_q;
	logic signed [31:0] offset_q;
	logic signed [31:0] act_pos_q;
	logic mv_pp_q;
	logic mv_rel_q;
	logic signed [31:0] mv_value_q;
	logic signed [31:0] target_q;
	logic reject_q;
	logic [31:0] rdata_q;
	logic ack_q;
	logic err_q;
	logic hw_pos_q;
	logic hw_neg_q;

	logic signed [31:0] cur_pos;
	logic signed [31:0] setp_pos;
	logic signed [32:0] cur_ext;
	logic signed [32:0] tgt_sum;
	logic signed [32:0] range_lo_ext;
	logic signed [32:0] range_hi_ext;
	logic act_below;
	logic act_above;
	logic tgt_below;
	logic tgt_above;
	logic sw_below;
	logic sw_above;
	logic clamp_below;
	logic clamp_above;
	logic act_out;
	logic tgt_out;
	logic sw_pos_trip;
	logic sw_neg_trip;
	logic sw_trip;
	logic hw_pos_trip;
	logic hw_neg_trip;
	logic hw_trip;
	logic abs_reject;
	logic dim_set;
	logic lat_clear_wr;
	logic signed [31:0] wdata_clamped;

	// Positions relative to the zero point held in offset_q
	assign cur_pos = ACT_RAW - offset_q;
	assign setp_pos = SETP_RAW - offset_q;
	assign cur_ext = {cur_pos[31], cur_pos};
	assign range_lo_ext = {aplm_pkg::RANGE_LO[31], aplm_pkg::RANGE_LO};
	assign range_hi_ext = {aplm_pkg::RANGE_HI[31], aplm_pkg::RANGE_HI};

	// Predicted target: relative moves add to the present position
	assign tgt_sum = mv_rel_q ? cur_ext + {mv_value_q[31], mv_value_q} : {mv_value_q[31], mv_value_q};

	// Actual position against the positioning range
	aplm_range_cmp u_range_act
	(
		.value(cur_ext),
		.lo(range_lo_ext),
		.hi(range_hi_ext),
		.below(act_below),
		.above(act_above)
	);

	// Predicted target against the positioning range
	aplm_range_cmp u_range_tgt
	(
		.value(tgt_sum),
		.lo(range_lo_ext),
		.hi(range_hi_ext),
		.below(tgt_below),
		.above(tgt_above)
	);

	// Setpoint against the software limit window
	aplm_range_cmp u_range_sw
	(
		.value({setp_pos[31], setp_pos}),
		.lo({soft_limit_negative_pos_q[31], soft_limit_negative_pos_q}),
		.hi({soft_limit_positive_pos_q[31], soft_limit_positive_pos_q}),
		.below(sw_below),
		.above(sw_above)
	);

	// Written limit value against the user range; only bites if the user range is narrowed
	aplm_range_cmp u_range_clamp
	(
		.value({PAR_WDATA[31], PAR_WDATA}),
		.lo({aplm_pkg::USR_MIN[31], aplm_pkg::USR_MIN}),
		.hi({aplm_pkg::USR_MAX[31], aplm_pkg::USR_MAX}),
		.below(clamp_below),
		.above(clamp_above)
	);

	// Clamp written software limit positions to the user range
	assign wdata_clamped = clamp_above ? aplm_pkg::USR_MAX : (clamp_below ? aplm_pkg::USR_MIN : PAR_WDATA);

	assign act_out = act_below | act_above;
	assign tgt_out = tgt_below | tgt_above;

	// Software limits only mean something once a zero point exists
	assign sw_pos_trip = ref_ok_q & soft_limit_enable_q[aplm_pkg::SLE_POS_BIT] & sw_above;
	assign sw_neg_trip = ref_ok_q & soft_limit_enable_q[aplm_pkg::SLE_NEG_BIT] & sw_below;
	assign sw_trip = sw_pos_trip | sw_neg_trip;

	// Hardware contact evaluation: disabled, active at 0, or active at 1
	assign hw_pos_trip = (pos_limit_input_eval_q == aplm_pkg::EVAL_ACT0 && !HW_LIMIT_POSITIVE_IN)
		|| (pos_limit_input_eval_q == aplm_pkg::EVAL_ACT1 && HW_LIMIT_POSITIVE_IN);
	assign hw_neg_trip = (neg_limit_input_eval_q == aplm_pkg::EVAL_ACT0 && !HW_LIMIT_NEGATIVE_IN)
		|| (neg_limit_input_eval_q == aplm_pkg::EVAL_ACT1 && HW_LIMIT_NEGATIVE_IN);
	assign hw_trip = MOVING & (hw_pos_trip | hw_neg_trip);

	// Check-cycle outcomes of a profile position move
	assign abs_reject = (state_q == aplm_pkg::MV_CHECK) && mv_pp_q && !mv_rel_q && tgt_out;
	assign dim_set = (state_q == aplm_pkg::MV_CHECK) && mv_pp_q && mv_rel_q && tgt_out;

	// Move start sequencer: capture, check, issue
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			state_q <= aplm_pkg::MV_IDLE;
			mv_pp_q <= 1'b0;
			mv_rel_q <= 1'b0;
			mv_value_q <= 32'sh00000000;
		end
		else
		begin
			case (state_q)
				aplm_pkg::MV_IDLE:
				begin
					if (MOVE_START)
					begin
						mv_pp_q <= MOVE_PP;
						mv_rel_q <= MOVE_REL;
						mv_value_q <= MOVE_VALUE;
						state_q <= aplm_pkg::MV_CHECK;
					end
				end
				aplm_pkg::MV_CHECK:
				begin
					state_q <= abs_reject ? aplm_pkg::MV_IDLE : aplm_pkg::MV_ISSUE;
				end
				aplm_pkg::MV_ISSUE:
				begin
					state_q <= aplm_pkg::MV_IDLE;
				end
				default:
				begin
					state_q <= aplm_pkg::MV_IDLE;
				end
			endcase
		end
	end

	// Target handed to the profile generator, relative to the zero point
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			target_q <= 32'sh00000000;
			reject_q <= 1'b0;
		end
		else
		begin
			reject_q <= abs_reject;
			if (state_q == aplm_pkg::MV_CHECK)
			begin
				// After the internal dimension setting the start point is 0
				target_q <= dim_set ? mv_value_q : tgt_sum[31:0];
			end
		end
	end

	// Zero point and reference validity; homing wins over any loss in the same cycle
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			offset_q <= 32'sh00000000;
			ref_ok_q <= 1'b0;
		end
		else if (HOME_DONE)
		begin
			offset_q <= ACT_RAW - HOME_POS;
			ref_ok_q <= 1'b1;
		end
		else
		begin
			if (dim_set)
			begin
				offset_q <= ACT_RAW;
			end
			if (dim_set || act_out)
			begin
				ref_ok_q <= 1'b0;
			end
		end
	end

	// Latched status: a new trip in the clearing cycle survives the clear
	assign lat_clear_wr = PAR_WR && (PAR_ADDR == aplm_pkg::ADDR_SIG_LATCHED);
	always_comb
	begin
		latched_signal_status_d = latched_signal_status_q;
		if (lat_clear_wr)
		begin
			latched_signal_status_d = latched_signal_status_q & ~PAR_WDATA[2:0];
		end
		latched_signal_status_d[aplm_pkg::LAT_SW_BIT] = latched_signal_status_d[aplm_pkg::LAT_SW_BIT] | sw_trip;
		latched_signal_status_d[aplm_pkg::LAT_HW_BIT] = latched_signal_status_d[aplm_pkg::LAT_HW_BIT] | hw_trip;
		latched_signal_status_d[0] = 1'b0;
	end

	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			latched_signal_status_q <= 3'h0;
			hw_pos_q <= 1'b0;
			hw_neg_q <= 1'b0;
			act_pos_q <= 32'sh00000000;
		end
		else
		begin
			latched_signal_status_q <= latched_signal_status_d;
			hw_pos_q <= MOVING & hw_pos_trip;
			hw_neg_q <= MOVING & hw_neg_trip;
			act_pos_q <= cur_pos;
		end
	end

	// Configuration writes; limit inputs come up disabled until configured
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			soft_limit_enable_q <= aplm_pkg::RST_SL_ENABLE;
			soft_limit_positive_pos_q <= aplm_pkg::RST_SL_POS;
			soft_limit_negative_pos_q <= aplm_pkg::RST_SL_NEG;
			pos_limit_input_eval_q <= aplm_pkg::RST_EVAL;
			neg_limit_input_eval_q <= aplm_pkg::RST_EVAL;
		end
		else if (PAR_WR)
		begin
			case (PAR_ADDR)
				aplm_pkg::ADDR_SL_ENABLE: soft_limit_enable_q <= PAR_WDATA[1:0];
				aplm_pkg::ADDR_SL_POS: soft_limit_positive_pos_q <= wdata_clamped;
				aplm_pkg::ADDR_SL_NEG: soft_limit_negative_pos_q <= wdata_clamped;
				aplm_pkg::ADDR_EVAL_POS: pos_limit_input_eval_q <= PAR_WDATA[1:0];
				aplm_pkg::ADDR_EVAL_NEG: neg_limit_input_eval_q <= PAR_WDATA[1:0];
				default: ;
			endcase
		end
	end

	// Read data and acknowledge, one cycle after the request
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			rdata_q <= 32'h00000000;
			ack_q <= 1'b0;
			err_q <= 1'b0;
		end
		else
		begin
			ack_q <= PAR_RD | PAR_WR;
			err_q <= 1'b0;
			if (PAR_RD)
			begin
				case (PAR_ADDR)
					aplm_pkg::ADDR_SL_ENABLE: rdata_q <= {30'h0, soft_limit_enable_q};
					aplm_pkg::ADDR_SL_POS: rdata_q <= soft_limit_positive_pos_q;
					aplm_pkg::ADDR_SL_NEG: rdata_q <= soft_limit_negative_pos_q;
					aplm_pkg::ADDR_SIG_LATCHED: rdata_q <= {29'h0, latched_signal_status_q};
					aplm_pkg::ADDR_EVAL_POS: rdata_q <= {30'h0, pos_limit_input_eval_q};
					aplm_pkg::ADDR_EVAL_NEG: rdata_q <= {30'h0, neg_limit_input_eval_q};
					aplm_pkg::ADDR_ACT_POS: rdata_q <= cur_pos;
					aplm_pkg::ADDR_REF_STATUS: rdata_q <= {31'h0, ref_ok_q};
					default:
					begin
						rdata_q <= 32'h00000000;
						err_q <= 1'b1;
					end
				endcase
			end
			else if (PAR_WR)
			begin
				// Read-only and unmapped addresses refuse writes
				case (PAR_ADDR)
					aplm_pkg::ADDR_SL_ENABLE, aplm_pkg::ADDR_SL_POS, aplm_pkg::ADDR_SL_NEG,
					aplm_pkg::ADDR_SIG_LATCHED, aplm_pkg::ADDR_EVAL_POS, aplm_pkg::ADDR_EVAL_NEG: err_q <= 1'b0;
					default: err_q <= 1'b1;
				endcase
			end
		end
	end

	// Outputs
	assign PAR_RDATA = rdata_q;
	assign PAR_ACK = ack_q;
	assign PAR_ERR = err_q;
	assign MOVE_GO = (state_q == aplm_pkg::MV_ISSUE);
	assign MOVE_REJECT = reject_q;
	assign MOVE_TARGET = target_q;
	assign REF_OK = ref_ok_q;
	// Stop holds until software acknowledges every latched trip
	assign STOP_MOTOR = |latched_signal_status_q;
	assign POS_LIMIT_HIT = hw_pos_q;
	assign NEG_LIMIT_HIT = hw_neg_q;
	assign SW_LIMIT_HIT = latched_signal_status_q[aplm_pkg::LAT_SW_BIT];
	// Position lags the feedback by one cycle so the readout never glitches mid-update
	assign ACT_POS = act_pos_q;

	// Overshoot of the range drops the reference point
	property p_ref_lost;
		@(posedge CLK) disable iff (RST) (act_out && !HOME_DONE) |=> !ref_ok_q;
	endproperty
	a_ref_lost: assert property (p_ref_lost) else $error("Reference kept after range overshoot");

	// Internal dimension setting zeroes the position and drops the reference
	property p_dim_zero;
		@(posedge CLK) disable iff (RST) (dim_set && !HOME_DONE) |=> (!ref_ok_q && offset_q == $past(ACT_RAW) && MOVE_GO);
	endproperty
	a_dim_zero: assert property (p_dim_zero) else $error("Dimension setting before relative move missing");

	// Absolute profile position move outside the range never starts
	property p_abs_reject;
		@(posedge CLK) disable iff (RST) abs_reject |=> (MOVE_REJECT && !MOVE_GO) ##1 !MOVE_GO;
	endproperty
	a_abs_reject: assert property (p_abs_reject) else $error("Out-of-range absolute move started");

	// Every start taken in idle is issued or rejected one cycle after its check
	property p_go_after_check;
		@(posedge CLK) disable iff (RST) (MOVE_START && state_q == aplm_pkg::MV_IDLE) |=> ##1 (MOVE_GO || MOVE_REJECT);
	endproperty
	a_go_after_check: assert property (p_go_after_check) else $error("Move start not answered in two cycles");

	// Software trip latches bit 2 and it needed a valid reference
	property p_sw_latch;
		@(posedge CLK) disable iff (RST) sw_trip |=> (SW_LIMIT_HIT && $past(ref_ok_q) && STOP_MOTOR);
	endproperty
	a_sw_latch: assert property (p_sw_latch) else $error("Software limit trip not latched");

	// Without a reference the software bit cannot rise
	property p_sw_needs_ref;
		@(posedge CLK) disable iff (RST) $rose(SW_LIMIT_HIT) |-> $past(ref_ok_q);
	endproperty
	a_sw_needs_ref: assert property (p_sw_needs_ref) else $error("Software limit tripped without reference");

	// Latched bit holds until a clearing write
	property p_sw_sticky;
		@(posedge CLK) disable iff (RST) (SW_LIMIT_HIT && !(lat_clear_wr && PAR_WDATA[2])) |=> SW_LIMIT_HIT;
	endproperty
	a_sw_sticky: assert property (p_sw_sticky) else $error("Latched software limit bit dropped");

	// Positive hardware trip during motion stops the motor and reports it
	property p_hw_stop;
		@(posedge CLK) disable iff (RST) (MOVING && hw_pos_trip) |=> (STOP_MOTOR && POS_LIMIT_HIT);
	endproperty
	a_hw_stop: assert property (p_hw_stop) else $error("Hardware limit did not stop motor");

	// Hardware bit only rises from a trip seen while moving
	property p_hw_moving;
		@(posedge CLK) disable iff (RST) $rose(latched_signal_status_q[aplm_pkg::LAT_HW_BIT]) |-> $past(MOVING);
	endproperty
	a_hw_moving: assert property (p_hw_moving) else $error("Hardware trip latched outside movement");

	// Actual position read returns the position at the request
	property p_act_read;
		@(posedge CLK) disable iff (RST) (PAR_RD && PAR_ADDR == aplm_pkg::ADDR_ACT_POS) |=> (PAR_ACK && PAR_RDATA == $past(cur_pos));
	endproperty
	a_act_read: assert property (p_act_read) else $error("Actual position read wrong");

endmodule

/* File: verif/aplm_limit_contacts.sv */
// Limit contact wiring model standing at the two axis end stops
`timescale 1ns/1ps
module aplm_limit_contacts
(
	// Axis standing on either end stop
	input wire logic at_pos,
	input wire logic at_neg,
	// Wiring: 1 normally closed contact, 0 normally open contact
	input wire logic nc_wiring,
	// Broken cable on both contacts
	input wire logic broken,
	// Contact levels seen by the drive
	output logic lim_pos,
	output logic lim_neg
);
	// A cut cable falls to the pull-down, so closed-contact wiring reads it as a trip
	assign lim_pos = broken ? 1'b0 : (nc_wiring ? ~at_pos : at_pos);
	assign lim_neg = broken ? 1'b0 : (nc_wiring ? ~at_neg : at_neg);
endmodule

/* File: verif/aplm_monitor_bench.sv */
// Self-checking bench for the axis position and limit monitor
`timescale 1ns/1ps
module aplm_monitor_bench;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [15:0] par_addr = 16'h0000;
	logic [31:0] par_wdata = 32'h00000000;
	logic par_wr = 1'b0;
	logic par_rd = 1'b0;
	logic [31:0] par_rdata;
	logic par_ack;
	logic par_err;
	logic signed [31:0] act_raw = 32'sh0;
	logic signed [31:0] setp_raw = 32'sh0;
	logic moving = 1'b0;
	logic move_start = 1'b0;
	logic move_pp = 1'b0;
	logic move_rel = 1'b0;
	logic signed [31:0] move_value = 32'sh0;
	logic move_go;
	logic move_reject;
	logic signed [31:0] move_target;
	logic home_done = 1'b0;
	logic signed [31:0] home_pos = 32'sh0;
	logic at_pos = 1'b0;
	logic at_neg = 1'b0;
	logic nc_wiring = 1'b1;
	logic broken = 1'b0;
	logic lim_pos;
	logic lim_neg;
	logic ref_ok;
	logic stop_motor;
	logic pos_hit;
	logic neg_hit;
	logic sw_hit;
	logic signed [31:0] act_pos;
	int failures = 0;
	int n_checks = 0;
	int cycles = 0;
	int i;
	logic signed [31:0] offset;
	logic [2:0] e;
	logic [1:0] res;
	logic [31:0] tgt;
	// Move table: profile position flag, relative flag, value; current position is 1000
	localparam logic MP [7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
	localparam logic MR [7] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
	localparam logic signed [31:0] MV [7] = '{aplm_pkg::RANGE_HI, aplm_pkg::RANGE_HI + 1, aplm_pkg::RANGE_LO,
		aplm_pkg::RANGE_LO - 1, aplm_pkg::RANGE_HI + 1, aplm_pkg::RANGE_HI - 1000, aplm_pkg::RANGE_HI - 999};

	aplm_monitor i_aplm_monitor (.CLK(clk), .RST(rst), .PAR_ADDR(par_addr), .PAR_WDATA(par_wdata),
		.PAR_WR(par_wr), .PAR_RD(par_rd), .PAR_RDATA(par_rdata), .PAR_ACK(par_ack), .PAR_ERR(par_err),
		.ACT_RAW(act_raw), .SETP_RAW(setp_raw), .MOVING(moving), .MOVE_START(move_start), .MOVE_PP(move_pp),
		.MOVE_REL(move_rel), .MOVE_VALUE(move_value), .MOVE_GO(move_go), .MOVE_REJECT(move_reject),
		.MOVE_TARGET(move_target), .HOME_DONE(home_done), .HOME_POS(home_pos),
		.HW_LIMIT_POSITIVE_IN(lim_pos), .HW_LIMIT_NEGATIVE_IN(lim_neg), .REF_OK(ref_ok),
		.STOP_MOTOR(stop_motor), .POS_LIMIT_HIT(pos_hit), .NEG_LIMIT_HIT(neg_hit), .SW_LIMIT_HIT(sw_hit),
		.ACT_POS(act_pos));

	aplm_limit_contacts i_aplm_limit_contacts (.at_pos(at_pos), .at_neg(at_neg), .nc_wiring(nc_wiring),
		.broken(broken), .lim_pos(lim_pos), .lim_neg(lim_neg));

	// 100 MHz clock
	always #5 clk = ~clk;

	// Hang guard, well above the length of the full sequence
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 6000)
		begin
			failures++;
			final_report();
		end
	end

	task automatic final_report;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic chk1(input string what, input logic seen, input logic exp);
		check(what, {31'h0, seen}, {31'h0, exp});
	endtask

	// Leaves the bench just after an edge, where registered outputs have settled
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// One parameter access; the strobe is a single-cycle pulse, the answer is awaited with a bound
	task automatic par(input logic wr, input logic [15:0] a, input logic [31:0] d, input logic [31:0] exp,
		input logic exp_err);
		int n;
		@(posedge clk);
		par_addr <= a;
		par_wdata <= d;
		par_wr <= wr;
		par_rd <= ~wr;
		@(posedge clk);
		par_wr <= 1'b0;
		par_rd <= 1'b0;
		#1;
		n = 0;
		while (par_ack !== 1'b1 && n < 4)
		begin
			tick(1);
			n++;
		end
		chk1("par_ack", par_ack, 1'b1);
		chk1("par_err", par_err, exp_err);
		if (!wr)
			check("par_rdata", par_rdata, exp);
	endtask

	task automatic home(input logic signed [31:0] hp);
		@(posedge clk);
		home_done <= 1'b1;
		home_pos <= hp;
		offset = act_raw - hp;
		@(posedge clk);
		home_done <= 1'b0;
		tick(2);
	endtask

	// Move request; the verdict is polled for a bounded number of cycles
	task automatic move(input logic pp, input logic rel, input logic signed [31:0] v);
		int n;
		@(posedge clk);
		move_start <= 1'b1;
		move_pp <= pp;
		move_rel <= rel;
		move_value <= v;
		@(posedge clk);
		move_start <= 1'b0;
		#1;
		n = 0;
		while (move_go !== 1'b1 && move_reject !== 1'b1 && n < 5)
		begin
			tick(1);
			n++;
		end
		res = {move_go, move_reject};
		tgt = move_target;
		tick(3);
	endtask

	// Expected {go, reject, reference kept} for a move from current position cur
	function automatic logic [2:0] exp_move(input logic pp, input logic rel, input longint cur, input longint v);
		longint t;
		bit ok;
		t = rel ? cur + v : v;
		ok = t >= longint'(aplm_pkg::RANGE_LO) && t <= longint'(aplm_pkg::RANGE_HI);
		if (!pp || ok)
			return 3'b101;
		// A refused absolute move leaves the zero point untouched
		return rel ? 3'b100 : 3'b011;
	endfunction

	// Drive the setpoint relative to the zero point and read the software trip flag
	task automatic sw_try(input logic signed [31:0] rel_sp, input logic exp);
		@(posedge clk);
		setp_raw <= offset + rel_sp;
		tick(3);
		chk1("sw_limit_hit", sw_hit, exp);
		@(posedge clk);
		setp_raw <= offset;
		tick(2);
		par(1'b1, aplm_pkg::ADDR_SIG_LATCHED, 32'h6, 32'h0, 1'b0);
	endtask

	initial
	begin
		void'($urandom(70269));
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		tick(1);
		par(1'b0, aplm_pkg::ADDR_SL_ENABLE, 32'h0, 32'h0, 1'b0);
		par(1'b0, aplm_pkg::ADDR_SL_POS, 32'h0, 32'h7fffffff, 1'b0);
		par(1'b0, aplm_pkg::ADDR_SL_NEG, 32'h0, 32'h80000000, 1'b0);
		par(1'b0, aplm_pkg::ADDR_EVAL_POS, 32'h0, 32'h0, 1'b0);
		par(1'b0, aplm_pkg::ADDR_REF_STATUS, 32'h0, 32'h0, 1'b0);
		par(1'b1, aplm_pkg::ADDR_ACT_POS, 32'h5, 32'h0, 1'b1);
		par(1'b0, 16'h0700, 32'h0, 32'h0, 1'b1);
		for (i = 0; i < 4; i++)
		begin
			par(1'b1, aplm_pkg::ADDR_SL_ENABLE, i, 32'h0, 1'b0);
			par(1'b0, aplm_pkg::ADDR_SL_ENABLE, 32'h0, i, 1'b0);
		end
		// Random position, no zero point yet: position reads raw
		@(posedge clk);
		act_raw <= $signed($urandom_range(200000000, 0)) - 100000000;
		setp_raw <= 32'sd5000;
		tick(2);
		par(1'b0, aplm_pkg::ADDR_ACT_POS, 32'h0, act_raw, 1'b0);
		check("act_pos", act_pos, act_raw);
		par(1'b1, aplm_pkg::ADDR_SL_POS, 32'd1000, 32'h0, 1'b0);
		par(1'b1, aplm_pkg::ADDR_SL_NEG, -32'sd1000, 32'h0, 1'b0);
		tick(2);
		chk1("sw_limit_hit", sw_hit, 1'b0);
		// Homing to a random position sets the zero point
		home($signed($urandom_range(20000, 0)) - 10000);
		chk1("ref_ok", ref_ok, 1'b1);
		par(1'b0, aplm_pkg::ADDR_ACT_POS, 32'h0, act_raw - offset, 1'b0);
		check("act_pos", act_pos, act_raw - offset);
		// The raw setpoint lies far outside the new window, so park it at zero and clear that trip first
		@(posedge clk);
		setp_raw <= offset;
		tick(2);
		par(1'b1, aplm_pkg::ADDR_SIG_LATCHED, 32'h4, 32'h0, 1'b0);
		chk1("sw_limit_hit", sw_hit, 1'b0);
		// Setpoint beyond the limit while actual stays inside trips and latches
		@(posedge clk);
		setp_raw <= offset + 1001;
		act_raw <= offset;
		tick(3);
		chk1("sw_limit_hit", sw_hit, 1'b1);
		chk1("stop_motor", stop_motor, 1'b1);
		par(1'b0, aplm_pkg::ADDR_SIG_LATCHED, 32'h0, 32'h4, 1'b0);
		@(posedge clk);
		setp_raw <= offset + 999;
		tick(3);
		chk1("sw_limit_hit", sw_hit, 1'b1);
		par(1'b1, aplm_pkg::ADDR_SIG_LATCHED, 32'h4, 32'h0, 1'b0);
		tick(2);
		chk1("sw_limit_hit", sw_hit, 1'b0);
		for (i = 0; i < 4; i++)
		begin
			par(1'b1, aplm_pkg::ADDR_SL_ENABLE, i, 32'h0, 1'b0);
			sw_try(32'sd1001, i[0]);
			sw_try(-32'sd1001, i[1]);
		end
		par(1'b1, aplm_pkg::ADDR_SL_ENABLE, 32'h0, 32'h0, 1'b0);
		// Hardware contact, every evaluation code, axis moving
		for (i = 0; i < 4; i++)
		begin
			@(posedge clk);
			nc_wiring <= (i != 2);
			par(1'b1, aplm_pkg::ADDR_EVAL_POS, i, 32'h0, 1'b0);
			@(posedge clk);
			at_pos <= 1'b1;
			moving <= 1'b1;
			tick(3);
			chk1("pos_limit_hit", pos_hit, i == 1 || i == 2);
			chk1("stop_motor", stop_motor, i == 1 || i == 2);
			@(posedge clk);
			at_pos <= 1'b0;
			moving <= 1'b0;
			tick(2);
			par(1'b1, aplm_pkg::ADDR_SIG_LATCHED, 32'h2, 32'h0, 1'b0);
		end
		// Broken cable on the negative contact: quiet while standing, trip while moving
		par(1'b1, aplm_pkg::ADDR_EVAL_NEG, 32'h1, 32'h0, 1'b0);
		@(posedge clk);
		nc_wiring <= 1'b1;
		broken <= 1'b1;
		tick(3);
		chk1("neg_limit_hit", neg_hit, 1'b0);
		@(posedge clk);
		moving <= 1'b1;
		tick(3);
		chk1("neg_limit_hit", neg_hit, 1'b1);
		par(1'b0, aplm_pkg::ADDR_SIG_LATCHED, 32'h0, 32'h2, 1'b0);
		@(posedge clk);
		moving <= 1'b0;
		broken <= 1'b0;
		tick(2);
		par(1'b1, aplm_pkg::ADDR_SIG_LATCHED, 32'h2, 32'h0, 1'b0);
		// Move table from current position 1000
		@(posedge clk);
		act_raw <= offset + 1000;
		tick(2);
		for (i = 0; i < 7; i++)
		begin
			e = exp_move(MP[i], MR[i], 1000, MV[i]);
			move(MP[i], MR[i], MV[i]);
			check("move verdict", {30'h0, res}, {30'h0, e[2:1]});
			chk1("ref_ok", ref_ok, e[0]);
			if (e[2])
				check("move_target", tgt, (MR[i] && e[0]) ? MV[i] + 1000 : MV[i]);
		end
		par(1'b0, aplm_pkg::ADDR_ACT_POS, 32'h0, 32'h0, 1'b0);
		check("act_pos", act_pos, 32'h0);
		// Actual position over the range bound drops the reference
		home(32'sh0);
		@(posedge clk);
		act_raw <= offset + aplm_pkg::RANGE_HI;
		tick(3);
		chk1("ref_ok", ref_ok, 1'b1);
		@(posedge clk);
		act_raw <= offset + aplm_pkg::RANGE_HI + 1;
		tick(3);
		chk1("ref_ok", ref_ok, 1'b0);
		final_report();
	end
endmodule
